// ---- rsi_pkg.sv ----
`default_nettype none
package rsi_pkg;

  // ************************************************************
  // Register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [5:0] SEC_CTRL_IDX  = 6'h2D;  // Security control b
  localparam logic [5:0] RX_STAT_IDX   = 6'h30;  // Receive MAC status
  localparam logic [5:0] EVT_STAT_IDX  = 6'h31;  // Event status
  localparam logic [5:0] EVT_MASK_IDX  = 6'h32;  // Event mask control

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int ENC_DIS_BIT    = 0;  // Encryption disable
  localparam int DEC_DIS_BIT    = 1;  // Decryption disable
  localparam int CIPHER_LSB     = 4;  // Beacon cipher suite low bit
  localparam int CIPHER_MSB     = 6;  // Beacon cipher suite high bit
  localparam int DEC_ERR_BIT    = 2;  // Decryption error flag
  localparam int BAT_LOW_BIT    = 5;  // Battery low flag
  localparam int MIC_ERR_BIT    = 6;  // Upper layer MIC error flag
  localparam int KEY_REQ_BIT    = 4;  // Key request event flag

  // ************************************************************
  // Reset values and write masks
  // ************************************************************
  localparam logic [7:0] EVT_STAT_RST  = 8'h00;  // All flags clear
  localparam logic [7:0] EVT_MASK_RST  = 8'hFF;  // All interrupts disabled
  localparam logic [7:0] SEC_CTRL_RST  = 8'h00;  // No cipher, nothing disabled
  localparam logic [7:0] SEC_CTRL_WMSK = 8'h73;  // Implemented security bits
  localparam logic [4:0] TAG_RST       = 5'h00;  // No tag after reset

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0] {
    RSI_CIPHER_NONE   = 3'b000,
    RSI_CIPHER_CTR    = 3'b001,
    RSI_CIPHER_CCM128 = 3'b010,
    RSI_CIPHER_CCM64  = 3'b011,
    RSI_CIPHER_CCM32  = 3'b100,
    RSI_CIPHER_CBC128 = 3'b101,
    RSI_CIPHER_CBC64  = 3'b110,
    RSI_CIPHER_CBC32  = 3'b111
  } rsi_cipher_type;

  // Event pulses in flag order, bit 7 first
  typedef struct packed {
    logic sleep_alert;    // Sleep alert
    logic wake_alert;     // Wake-up alert
    logic half_symbol;    // Half symbol timer
    logic secured_frame;  // Received frame with security bit set
    logic rx_fifo;        // Receive FIFO reception
    logic slot2_tx;       // Slot 2 transmit done
    logic slot1_tx;       // Slot 1 transmit done
    logic normal_tx;      // Normal FIFO transmit done
  } rsi_events_type;

  // Register access taken this cycle
  typedef struct packed {
    logic       read;   // Read accepted
    logic       write;  // Write accepted, low byte enabled
    logic [5:0] index;  // Register index
    logic [7:0] wdata;  // Write data low byte
  } rsi_access_type;

  // Tag length in bytes for a cipher suite
  function automatic logic [4:0] rsi_tag_bytes(input rsi_cipher_type suite);
    logic [4:0] len;
    len = 5'h00;
    unique case (suite)
      RSI_CIPHER_CCM128, RSI_CIPHER_CBC128: len = 5'h10;
      RSI_CIPHER_CCM64,  RSI_CIPHER_CBC64:  len = 5'h08;
      RSI_CIPHER_CCM32,  RSI_CIPHER_CBC32:  len = 5'h04;
      RSI_CIPHER_NONE,   RSI_CIPHER_CTR:    len = 5'h00;
    endcase
    return len;
  endfunction : rsi_tag_bytes

endpackage : rsi_pkg
`default_nettype wire

// ---- rsi_wb_slave.sv ----
`timescale 1ns/1ps
`default_nettype none
module rsi_wb_slave (
  input  wire logic                    clk,        // System clock
  input  wire logic                    rst_b,      // Async reset, active low
  input  wire logic                    ce,         // Clock enable
  input  wire logic                    wb_cyc_i,   // Bus cycle
  input  wire logic                    wb_stb_i,   // Strobe
  input  wire logic                    wb_we_i,    // Write enable
  input  wire logic [7:0]              wb_adr_i,   // Byte address
  input  wire logic [3:0]              wb_sel_i,   // Byte selects
  input  wire logic [31:0]             wb_dat_i,   // Write data
  input  wire logic [7:0]              rdata,      // Selected register value
  output logic      [31:0]             wb_dat_o,   // Read data
  output logic                         wb_ack_o,   // Acknowledge
  output rsi_pkg::rsi_access_type      acc         // Access taken this cycle
);

  // ************************************************************
  // Bus handshake
  // ************************************************************
  logic        ack_reg;   // Acknowledge flop
  logic        ack_next;  // Next acknowledge
  logic [31:0] dat_reg;   // Read data flop
  logic [31:0] dat_next;  // Next read data

  // Answer one cycle after the request, then drop
  always_comb begin
    ack_next  = wb_cyc_i & wb_stb_i & ~ack_reg;
    acc.read  = ack_next & ~wb_we_i;
    acc.write = ack_next & wb_we_i & wb_sel_i[0];
    acc.index = wb_adr_i[7:2];
    acc.wdata = wb_dat_i[7:0];
    // Upper lanes always zero, unmapped reads zero
    dat_next  = acc.read ? {24'h000000, rdata} : 32'h00000000;
  end

  // Registers the handshake
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end else if (ce) begin
      ack_reg <= ack_next;
      dat_reg <= dat_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // Acknowledge lasts one cycle
  a_ack_one_cycle: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && wb_ack_o) |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

endmodule : rsi_wb_slave
`default_nettype wire

// ---- rsi_event_collect.sv ----
`timescale 1ns/1ps
`default_nettype none
module rsi_event_collect (
  input  wire logic       clk,       // System clock
  input  wire logic       rst_b,     // Async reset, active low
  input  wire logic       ce,        // Clock enable
  input  wire logic [7:0] set_i,     // Event pulses in flag order
  input  wire logic       rd_clr_i,  // Status register read
  output logic      [7:0] status_o   // Sticky flags
);

  // ************************************************************
  // Sticky read-to-clear flags
  // ************************************************************
  logic [7:0] status_reg;   // Flag flops
  logic [7:0] status_next;  // Next flags

  // New event beats the read clear in the same cycle
  always_comb begin
    status_next = (rd_clr_i ? 8'h00 : status_reg) | set_i;
  end

  // Registers the flags
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status_reg <= rsi_pkg::EVT_STAT_RST;
    end else if (ce) begin
      status_reg <= status_next;
    end
  end

  assign status_o = status_reg;

  a_flag_set_sticks: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && set_i != 8'h00) |=> ((status_o & $past(set_i)) == $past(set_i)))
    else $error("event did not set its flag");

  a_read_clears_all: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && rd_clr_i && set_i == 8'h00) |=> (status_o == 8'h00))
    else $error("status read did not clear flags");

  a_flags_reset_zero: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(rst_b) |-> (status_o == 8'h00))
    else $error("flags not zero after reset");

endmodule : rsi_event_collect
`default_nettype wire

// ---- rsi_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module rsi_top (
  input  wire logic                    clk,                 // System clock, 100 MHz
  input  wire logic                    rst_b,               // Power-on reset, active low
  input  wire logic                    ce,                  // Clock enable, freezes state when low
  input  wire logic                    wb_cyc_i,            // Wishbone cycle
  input  wire logic                    wb_stb_i,            // Wishbone strobe
  input  wire logic                    wb_we_i,             // Wishbone write enable
  input  wire logic [7:0]              wb_adr_i,            // Wishbone byte address
  input  wire logic [3:0]              wb_sel_i,            // Wishbone byte selects
  input  wire logic [31:0]             wb_dat_i,            // Wishbone write data
  output logic      [31:0]             wb_dat_o,            // Wishbone read data
  output logic                         wb_ack_o,            // Wishbone acknowledge
  input  wire rsi_pkg::rsi_events_type events_i,            // Event pulses
  input  wire logic                    mic_error_i,         // MIC error pulse
  input  wire logic                    decrypt_error_i,     // Decryption error level
  input  wire logic                    battery_low_i,       // Supply below threshold level
  input  wire logic                    tx_security_req_i,   // Packet asks for encryption
  output logic                         irq_o,               // Interrupt request, high active
  output logic                         tx_encrypt_o,        // Encrypt the packet being sent
  output rsi_pkg::rsi_cipher_type      beacon_cipher_o,     // Beacon cipher suite
  output logic      [4:0]              beacon_tag_bytes_o   // Beacon tag length in bytes
);

  // ************************************************************
  // Bus slave
  // ************************************************************
  rsi_pkg::rsi_access_type acc;    // Access taken this cycle
  logic [7:0]              rdata;  // Read mux output

  rsi_wb_slave u_bus (
    .clk      (clk),
    .rst_b    (rst_b),
    .ce       (ce),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_sel_i (wb_sel_i),
    .wb_dat_i (wb_dat_i),
    .rdata    (rdata),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .acc      (acc)
  );

  // ************************************************************
  // Access decode
  // ************************************************************
  logic wr_sec;   // Write to security control
  logic wr_rx;    // Write to receive status
  logic wr_mask;  // Write to event mask
  logic rd_evt;   // Read of event status

  // Strobes per register, writes to event status ignored
  always_comb begin
    wr_sec  = acc.write && (acc.index == rsi_pkg::SEC_CTRL_IDX);
    wr_rx   = acc.write && (acc.index == rsi_pkg::RX_STAT_IDX);
    wr_mask = acc.write && (acc.index == rsi_pkg::EVT_MASK_IDX);
    rd_evt  = acc.read  && (acc.index == rsi_pkg::EVT_STAT_IDX);
  end

  // ************************************************************
  // Security control
  // ************************************************************
  logic [7:0] sec_reg;   // Security control flops
  logic [7:0] sec_next;  // Next security control
  logic       dec_dis;   // Decryption disable
  logic       enc_dis;   // Encryption disable

  // Only implemented bits take writes, reserved stay zero
  always_comb begin
    sec_next = sec_reg;
    if (wr_sec) begin
      sec_next = acc.wdata & rsi_pkg::SEC_CTRL_WMSK;
    end
  end

  // Registers security control
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sec_reg <= rsi_pkg::SEC_CTRL_RST;
    end else if (ce) begin
      sec_reg <= sec_next;
    end
  end

  assign dec_dis = sec_reg[rsi_pkg::DEC_DIS_BIT];
  assign enc_dis = sec_reg[rsi_pkg::ENC_DIS_BIT];

  // ************************************************************
  // Event flags
  // ************************************************************
  logic [7:0] evt_set;     // Event pulses in flag order
  logic [7:0] evt_status;  // Sticky event flags

  // Secured frames raise a key request unless decryption is off
  always_comb begin
    evt_set = events_i;
    evt_set[rsi_pkg::KEY_REQ_BIT] = events_i.secured_frame & ~dec_dis;
  end

  rsi_event_collect u_events (
    .clk      (clk),
    .rst_b    (rst_b),
    .ce       (ce),
    .set_i    (evt_set),
    .rd_clr_i (rd_evt),
    .status_o (evt_status)
  );

  // ************************************************************
  // Event mask, one disables
  // ************************************************************
  logic [7:0] mask_reg;   // Mask flops
  logic [7:0] mask_next;  // Next mask

  // Plain read-write register
  always_comb begin
    mask_next = mask_reg;
    if (wr_mask) begin
      mask_next = acc.wdata;
    end
  end

  // Registers the mask
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mask_reg <= rsi_pkg::EVT_MASK_RST;
    end else if (ce) begin
      mask_reg <= mask_next;
    end
  end

  // ************************************************************
  // Receive status
  // ************************************************************
  logic mic_reg;    // MIC error flag
  logic mic_next;   // Next MIC error flag
  logic dec_reg;    // Sampled decryption error
  logic dec_next;   // Next decryption error
  logic bat_reg;    // Sampled battery low
  logic bat_next;   // Next battery low
  logic mic_clr;    // Software clears MIC flag

  // MIC flag set wins over the write-one clear
  always_comb begin
    mic_clr  = wr_rx && acc.wdata[rsi_pkg::MIC_ERR_BIT];
    mic_next = mic_error_i | (mic_reg & ~mic_clr);
    dec_next = decrypt_error_i;
    bat_next = battery_low_i;
  end

  // Registers receive status
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mic_reg <= 1'b0;
      dec_reg <= 1'b0;
      bat_reg <= 1'b0;
    end else if (ce) begin
      mic_reg <= mic_next;
      dec_reg <= dec_next;
      bat_reg <= bat_next;
    end
  end

  // ************************************************************
  // Read mux
  // ************************************************************
  logic [7:0] rx_word;  // Receive status as read

  // Unmapped indices read zero
  always_comb begin
    rx_word = 8'h00;
    rx_word[rsi_pkg::MIC_ERR_BIT] = mic_reg;
    rx_word[rsi_pkg::BAT_LOW_BIT] = bat_reg;
    rx_word[rsi_pkg::DEC_ERR_BIT] = dec_reg;
    unique case (acc.index)
      rsi_pkg::SEC_CTRL_IDX: rdata = sec_reg;
      rsi_pkg::RX_STAT_IDX:  rdata = rx_word;
      rsi_pkg::EVT_STAT_IDX: rdata = evt_status;
      rsi_pkg::EVT_MASK_IDX: rdata = mask_reg;
      default:               rdata = 8'h00;
    endcase
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  logic                    irq_cause;   // Unmasked flag present
  logic                    irq_reg;     // Interrupt flop
  logic                    enc_reg;     // Encrypt flop
  logic                    enc_next;    // Next encrypt
  rsi_pkg::rsi_cipher_type cipher;      // Selected beacon suite
  logic [4:0]              tag_reg;     // Tag length flop
  logic [4:0]              tag_next;    // Next tag length

  // Flags gated by the same bit position of the mask
  always_comb begin
    irq_cause = (evt_status & ~mask_reg) != 8'h00;
    enc_next  = tx_security_req_i & ~enc_dis;
    cipher    = rsi_pkg::rsi_cipher_type'(sec_reg[rsi_pkg::CIPHER_MSB:rsi_pkg::CIPHER_LSB]);
    tag_next  = rsi_pkg::rsi_tag_bytes(cipher);
  end

  // Registers outputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_reg <= 1'b0;
      enc_reg <= 1'b0;
      tag_reg <= rsi_pkg::TAG_RST;
    end else if (ce) begin
      irq_reg <= irq_cause;
      enc_reg <= enc_next;
      tag_reg <= tag_next;
    end
  end

  assign irq_o              = irq_reg;
  assign tx_encrypt_o       = enc_reg;
  assign beacon_cipher_o    = cipher;
  assign beacon_tag_bytes_o = tag_reg;

  // ************************************************************
  // Checks
  // ************************************************************
  a_write_keeps_flags: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && acc.write && acc.index == rsi_pkg::EVT_STAT_IDX)
      |=> ((evt_status & $past(evt_status)) == $past(evt_status)))
    else $error("write cleared event flags");

  a_mask_resets_high: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(rst_b) |-> (mask_reg == 8'hFF && !irq_o))
    else $error("mask not all ones after reset");

  a_irq_follows_mask: assert property (@(posedge clk) disable iff (!rst_b)
    ce |=> (irq_o == $past(irq_cause)))
    else $error("interrupt does not follow unmasked flags");

  a_masked_no_irq: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && mask_reg == 8'hFF) |=> !irq_o)
    else $error("interrupt with all bits masked");

  a_key_req_blocked: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && dec_dis && !evt_status[rsi_pkg::KEY_REQ_BIT] && !wr_sec)
      |=> !evt_status[rsi_pkg::KEY_REQ_BIT])
    else $error("key request raised with decryption disabled");

  a_no_encrypt_off: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && enc_dis) |=> !tx_encrypt_o)
    else $error("encryption while disabled");

  a_cipher_tag_len: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && cipher == rsi_pkg::RSI_CIPHER_CCM64) |=> (beacon_tag_bytes_o == 5'h08))
    else $error("wrong tag length for suite");

  a_mic_flag_sticky: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && mic_reg && !mic_clr) |=> mic_reg [*1] ##0 (rx_word[6] == 1'b1))
    else $error("MIC flag lost without clear");

  a_mic_sets: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && mic_error_i) |=> mic_reg)
    else $error("MIC error not flagged");

  a_dec_err_track: assert property (@(posedge clk) disable iff (!rst_b)
    ce |=> (rx_word[2] == $past(decrypt_error_i)))
    else $error("decryption error flag wrong");

  a_bat_low_track: assert property (@(posedge clk) disable iff (!rst_b)
    ce |=> (rx_word[5] == $past(battery_low_i)))
    else $error("battery low flag wrong");

  a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_b)
    (sec_reg[7] == 1'b0) && (sec_reg[3:2] == 2'b00) && (rx_word[7] == 1'b0))
    else $error("reserved bit reads one");

  a_mask_write_lands: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && wr_mask) |=> (mask_reg == $past(acc.wdata)))
    else $error("mask write not stored");

  a_cipher_write_lands: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && wr_sec) |=> (sec_reg[rsi_pkg::CIPHER_MSB:rsi_pkg::CIPHER_LSB] == $past(acc.wdata[6:4])))
    else $error("cipher field write not stored");

  a_mic_write_clears: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && mic_clr && !mic_error_i) |=> !mic_reg)
    else $error("MIC flag not cleared by write one");

  a_key_req_raised: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && events_i.secured_frame && !dec_dis) |=> evt_status[rsi_pkg::KEY_REQ_BIT])
    else $error("key request missing with decryption on");

  a_enc_follows_req: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && !enc_dis) |=> (tx_encrypt_o == $past(tx_security_req_i)))
    else $error("encrypt output does not follow request");

  a_ce_freezes_state: assert property (@(posedge clk) disable iff (!rst_b) // Clock enable low
    !ce |=> ($stable(sec_reg) && $stable(mask_reg) && $stable(evt_status) && $stable(irq_o)))
    else $error("state changed with clock enable low");

endmodule : rsi_top
`default_nettype wire

// ---- rsi_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Host software model on the register bus
// ****************************************
module rsi_host (
  input  wire logic        clk,    // System clock
  input  wire logic [31:0] dat_i,  // Read data
  input  wire logic        ack,    // Acknowledge
  output logic             cyc,    // Cycle
  output logic             stb,    // Strobe
  output logic             we,     // Write enable
  output logic      [7:0]  adr,    // Byte address
  output logic      [3:0]  sel,    // Byte selects
  output logic      [31:0] dat_o   // Write data
);
  // Bus idle at time zero
  initial begin
    {cyc, stb, we, adr, sel, dat_o} = '0;
  end

  // One classic cycle, held until ack, bounded wait
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, sel, dat_o} <= {2'b11, w, a, 4'hF, 24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = dat_i;
    {cyc, stb} <= 2'b00;
    if (n >= 50) begin
      radio_irq_and_security_status_bench.mismatches++;
      radio_irq_and_security_status_bench.tally_and_finish();
    end
  endtask : xfer
endmodule : rsi_host
`default_nettype wire

// ---- radio_irq_and_security_status_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
// ****************************************
// Self-checking bench
// ****************************************
module radio_irq_and_security_status_bench;
  logic                    clk = 1'b0;  // System clock
  logic                    rst_b = 1'b0;  // Reset, active low
  logic                    cyc, stb, we, ack, irq, txe, mic, derr, bat, txr, ce = 1'b1;  // Bus, side pins, enable
  logic [7:0]              adr;  // Address
  logic [3:0]              sel;  // Byte selects
  logic [31:0]             wd, dout, q;  // Bus data, read word
  rsi_pkg::rsi_events_type ev;  // Event pulses
  rsi_pkg::rsi_cipher_type ciph;  // Beacon suite
  logic [4:0]              tag;  // Tag length
  int                      mismatches = 0, checked = 0, seed = 32'h09a10c4b;  // Counters, seed
  int                      stat = 0, mask = 255, sec = 0, v;  // Reference model state

  always #5 clk = ~clk;  // 100 MHz

  rsi_top DUT (.clk(clk), .rst_b(rst_b), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(dout), .wb_ack_o(ack), .events_i(ev),
    .mic_error_i(mic), .decrypt_error_i(derr), .battery_low_i(bat), .tx_security_req_i(txr),
    .irq_o(irq), .tx_encrypt_o(txe), .beacon_cipher_o(ciph), .beacon_tag_bytes_o(tag));
  rsi_host HOST (.clk(clk), .dat_i(dout), .ack(ack), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
    .sel(sel), .dat_o(wd));

  // Register write
  task automatic wr(input logic [7:0] a, input int d);
    HOST.xfer(1'b1, a, d[7:0], q);
  endtask : wr

  // Register read and compare
  task automatic rd_chk(input logic [7:0] a, input int e);
    HOST.xfer(1'b0, a, 8'h00, q);
    `CHK(q, e[7:0])
  endtask : rd_chk

  // Event and MIC pulse, one cycle; returns once irq has settled
  task automatic pulse(input int e, input logic m);
    @(posedge clk);
    ev <= e[7:0];
    mic <= m;
    @(posedge clk);
    ev <= 8'h00;
    mic <= 1'b0;
    @(posedge clk);
    #1;
  endtask : pulse

  // Verdict and end of run
  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {ev, mic, derr, bat, txr} = '0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rd_chk(8'hB4, 0);
    rd_chk(8'hC0, 0);
    rd_chk(8'hC4, 0);
    rd_chk(8'hC8, 255);
    rd_chk(8'h10, 0);  // Unmapped reads zero
    $display("test reset values done");
    for (v = 0; v < 8; v++) begin
      wr(8'hB4, v * 16 + 140);
      @(posedge clk);
      #1;
      `CHK(ciph, v[2:0])
      `CHK(tag, (v < 2) ? 0 : 16 >> ((v - 2) % 3))
      rd_chk(8'hB4, v * 16);
    end
    $display("test cipher suites done");
    for (v = 0; v < 4; v++) begin
      wr(8'hB4, v);
      txr <= v[1];
      repeat (2) @(posedge clk);
      #1;
      `CHK(txe, v[1] & ~v[0])
    end
    $display("test encryption disable done");
    for (int i = 0; i < 24; i++) begin
      sec = $random(seed) & 3;
      wr(8'hB4, sec);
      mask = $random(seed) & 255;
      wr(8'hC8, mask);
      v = $random(seed) & 255;
      if (i % 4 == 0) v |= 16;
      pulse(v, 1'b0);
      wr(8'hC4, 255);
      stat |= v & (sec[1] ? 239 : 255);
      `CHK(irq, |(stat & ~mask & 255))
      rd_chk(8'hC8, mask);
      rd_chk(8'hC4, stat);
      stat = 0;
      rd_chk(8'hC4, 0);
    end
    $display("test events and mask done");
    mask = 0;
    wr(8'hC8, mask);
    ce <= 1'b0;
    pulse(255, 1'b1);
    `CHK(irq, 1'b0)
    @(posedge clk);
    ce <= 1'b1;
    rd_chk(8'hC4, 0);
    rd_chk(8'hC0, 0);
    rd_chk(8'hC8, mask);
    $display("test clock enable done");
    for (v = 0; v < 4; v++) begin
      derr <= v[0];
      bat <= v[1];
      pulse(0, 1'b1);
      wr(8'hC0, 8'hBF);
      rd_chk(8'hC0, 64 + v[1] * 32 + v[0] * 4);
      wr(8'hC0, 8'h40);
      rd_chk(8'hC0, v[1] * 32 + v[0] * 4);
    end
    $display("test receive status done");
    tally_and_finish();
  end
endmodule : radio_irq_and_security_status_bench
`default_nettype wire
